//--- hdl/cfb_pkg.sv
/*
  constants for the cell flag, balance status and fuse trigger registers,
  and for the 24-bit serial frame that reaches them.
  assumes the serial port carries one 7-bit address and one 16-bit word.
*/
package cfb_pkg;
  // register geometry
  localparam int REG_W = 16;
  localparam int ADDR_W = 7;
  localparam int CELLS = 17;
  // offsets
  localparam logic [6:0] UV_FLAGS_LOW_OFS = 7'h4f;
  localparam logic [6:0] UV_FLAGS_HIGH_OFS = 7'h50;
  localparam logic [6:0] BAL_STATE_LOW_OFS = 7'h51;
  localparam logic [6:0] BAL_STATE_HIGH_OFS = 7'h52;
  localparam logic [6:0] FUSE_TRIGGER_OFS = 7'h53;
  // fields
  localparam int UV17_BIT = 0;
  localparam int UV_RSVD_LSB = 1;
  localparam int UV_RSVD_MSB = 5;
  localparam int BAL17_BIT = 0;
  localparam int FUSE_W = 8;
  localparam logic [7:0] FUSE_CODE = 8'hfb;
  localparam logic [15:0] CLEAR_VALUE = 16'h0000;
  // reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [4:0] UV_RSVD_RESET = 5'h00;
  localparam logic [7:0] FUSE_RESET = 8'h00;
  // frame layout: command byte (write flag, address) then data word
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int WRITE_FLAG_BIT = 7;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_CMD_DONE = 5'h08;
  localparam logic [4:0] CNT_FRAME_DONE = 5'h18;
  // frame state
  typedef enum logic [2:0] {
    CFB_IDLE = 3'b001,
    CFB_CMD = 3'b010,
    CFB_DATA = 3'b100
  } cfb_state_t;
endpackage

//--- hdl/cfb_spi_shift.sv
/*
  bit-level serial shifter, mode 0, msb first, one clock domain.
  assumes sclk, cs_n and mosi are synchronous to mclk and that sclk
  is slower than mclk/4 so every edge is seen.
*/
`timescale 1ns/1ps
`default_nettype none
module cfb_spi_shift #(
  parameter int WORD_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // word to send, armed by a pulse, put out at the next falling edge
  input wire logic tx_arm,
  input wire logic [WORD_W-1:0] tx_word,
  // received bits and frame edges
  output logic bit_valid,
  output logic bit_value,
  output logic frame_start,
  output logic frame_end
);
  logic sclk_q, sclk_d;
  logic cs_n_q, cs_n_d;
  logic pend_q, pend_d;
  logic [WORD_W-1:0] tx_q, tx_d;
  logic rise, fall;

  assign rise = sclk & ~sclk_q & ~cs_n;
  assign fall = ~sclk & sclk_q & ~cs_n;

  always_comb begin
    sclk_d = sclk;
    cs_n_d = cs_n;
    pend_d = pend_q;
    tx_d = tx_q;
    if (cs_n) begin
      pend_d = 1'b0;
      tx_d = '0;
    end else if (fall) begin
      // loading on the edge keeps bit 15 valid before the next rise
      if (pend_q) begin
        tx_d = tx_word;
        pend_d = 1'b0;
      end else begin
        tx_d = {tx_q[WORD_W-2:0], 1'b0};
      end
    end
    if (tx_arm) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      pend_q <= 1'b0;
      tx_q <= '0;
    end else begin
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      pend_q <= pend_d;
      tx_q <= tx_d;
    end
  end

  assign miso = tx_q[WORD_W-1];
  assign miso_oe_n = cs_n_q;
  assign bit_valid = rise;
  assign bit_value = mosi;
  assign frame_start = cs_n_q & ~cs_n;
  assign frame_end = ~cs_n_q & cs_n;
endmodule
`default_nettype wire

//--- hdl/cfb_regs.sv
/*
  cell 17 undervoltage flag, cell balance status and fuse trigger
  registers behind a serial port with 16-bit words.
  assumes detect and balance inputs are synchronous to mclk; the flags
  of cells 1 to 16 live elsewhere and are cleared by uv_clear_pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module cfb_regs #(
  parameter int CELLS = 17
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // chip side
  input wire logic cell17_uv_detect,
  input wire logic [CELLS-1:0] cell_balance_on,
  output logic cell17_undervoltage_latch,
  output logic uv_clear_pulse,
  output logic fuse_drive
);
  logic bit_valid, bit_value, frame_start, frame_end;
  logic tx_arm;
  cfb_pkg::cfb_state_t state_q, state_d;
  logic [cfb_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [cfb_pkg::CMD_BITS-1:0] cmd_q, cmd_d;
  logic [cfb_pkg::REG_W-1:0] wdata_q, wdata_d;
  logic [cfb_pkg::REG_W-1:0] rdata_q, rdata_d;
  logic [cfb_pkg::REG_W-1:0] rd_mux;
  logic commit;
  logic [cfb_pkg::ADDR_W-1:0] addr;
  logic [cfb_pkg::ADDR_W-1:0] rd_addr;
  logic is_write;
  // register state
  logic uv17_q, uv17_d;
  logic [4:0] uv_rsvd_q, uv_rsvd_d;
  logic [cfb_pkg::FUSE_W-1:0] fuse_q, fuse_d;
  logic fuse_drive_q, fuse_drive_d;
  logic clr_q, clr_d;
  logic uv_clear;

  cfb_spi_shift #(
    .WORD_W(cfb_pkg::REG_W)
  ) i_cfb_spi_shift (
    .mclk(mclk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    // miso shows zero during the command byte; the word follows the 8th fall
    .tx_arm(tx_arm),
    .tx_word(rdata_q),
    .bit_valid(bit_valid),
    .bit_value(bit_value),
    .frame_start(frame_start),
    .frame_end(frame_end)
  );

  assign addr = cmd_q[cfb_pkg::ADDR_W-1:0];
  // bit 7 of the command byte selects a write, the rest is the offset
  assign is_write = cmd_q[cfb_pkg::WRITE_FLAG_BIT];
  // offset including the bit arriving now; built apart from cmd_d so the
  // read view and the sequencer do not form a combinational loop
  assign rd_addr = {cmd_q[cfb_pkg::ADDR_W-2:0], bit_value};

  // read view; offsets not held here, 0x4f among them, read as zero
  always_comb begin
    rd_mux = cfb_pkg::REG_RESET;
    case (rd_addr)
      cfb_pkg::UV_FLAGS_HIGH_OFS: begin
        rd_mux[cfb_pkg::UV17_BIT] = uv17_q;
        rd_mux[cfb_pkg::UV_RSVD_MSB:cfb_pkg::UV_RSVD_LSB] = uv_rsvd_q;
      end
      cfb_pkg::BAL_STATE_LOW_OFS: begin
        rd_mux = cell_balance_on[cfb_pkg::REG_W-1:0];
      end
      cfb_pkg::BAL_STATE_HIGH_OFS: begin
        rd_mux[cfb_pkg::BAL17_BIT] = cell_balance_on[CELLS-1];
      end
      cfb_pkg::FUSE_TRIGGER_OFS: begin
        rd_mux[cfb_pkg::FUSE_W-1:0] = fuse_q;
      end
      default: begin
        rd_mux = cfb_pkg::REG_RESET;
      end
    endcase
  end

  // frame sequencing: command byte, then the data word
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    tx_arm = 1'b0;
    commit = 1'b0;
    case (state_q)
      cfb_pkg::CFB_IDLE: begin
        if (frame_start) begin
          state_d = cfb_pkg::CFB_CMD;
          cnt_d = cfb_pkg::CNT_ZERO;
        end
      end
      cfb_pkg::CFB_CMD: begin
        if (frame_end) begin
          state_d = cfb_pkg::CFB_IDLE;
        end else if (bit_valid) begin
          cmd_d = {cmd_q[cfb_pkg::CMD_BITS-2:0], bit_value};
          cnt_d = cnt_q + 1'b1;
          if (cnt_d == cfb_pkg::CNT_CMD_DONE) begin
            // read data is frozen here so the word cannot tear mid-shift
            rdata_d = rd_mux;
            tx_arm = 1'b1;
            state_d = cfb_pkg::CFB_DATA;
          end
        end
      end
      cfb_pkg::CFB_DATA: begin
        if (frame_end) begin
          state_d = cfb_pkg::CFB_IDLE;
          // short or long frames are dropped without effect
          commit = is_write && (cnt_q == cfb_pkg::CNT_FRAME_DONE);
        end else if (bit_valid) begin
          wdata_d = {wdata_q[cfb_pkg::REG_W-2:0], bit_value};
          // stops one past a full frame so a long frame never wraps to 24
          if (cnt_q != cfb_pkg::CNT_FRAME_DONE + 1'b1) begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      default: begin
        // an illegal state code returns to idle instead of locking the port
        state_d = cfb_pkg::CFB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= cfb_pkg::CFB_IDLE;
      cnt_q <= cfb_pkg::CNT_ZERO;
      cmd_q <= '0;
      wdata_q <= cfb_pkg::REG_RESET;
      rdata_q <= cfb_pkg::REG_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end

  // a zero word to either flag register clears every latched flag
  assign uv_clear = commit && (wdata_q == cfb_pkg::CLEAR_VALUE) &&
    ((addr == cfb_pkg::UV_FLAGS_LOW_OFS) ||
     (addr == cfb_pkg::UV_FLAGS_HIGH_OFS));

  always_comb begin
    uv17_d = uv17_q;
    uv_rsvd_d = uv_rsvd_q;
    fuse_d = fuse_q;
    clr_d = uv_clear;
    if (commit && (addr == cfb_pkg::UV_FLAGS_HIGH_OFS)) begin
      // bits 15:6 are read-only and keep zero
      uv_rsvd_d = wdata_q[cfb_pkg::UV_RSVD_MSB:cfb_pkg::UV_RSVD_LSB];
    end
    if (commit && (addr == cfb_pkg::FUSE_TRIGGER_OFS)) begin
      fuse_d = wdata_q[cfb_pkg::FUSE_W-1:0];
    end
    if (uv_clear) begin
      uv17_d = 1'b0;
    end
    // a detect in the clearing cycle is kept: set wins
    if (cell17_uv_detect) begin
      uv17_d = 1'b1;
    end
    // decoded from the next field so the driver moves with the field
    fuse_drive_d = (fuse_d == cfb_pkg::FUSE_CODE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // only the latch, the stored bits and the fuse field outlive a frame
      uv17_q <= 1'b0;
      uv_rsvd_q <= cfb_pkg::UV_RSVD_RESET;
      fuse_q <= cfb_pkg::FUSE_RESET;
      fuse_drive_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      uv17_q <= uv17_d;
      uv_rsvd_q <= uv_rsvd_d;
      fuse_q <= fuse_d;
      fuse_drive_q <= fuse_drive_d;
      clr_q <= clr_d;
    end
  end

  assign cell17_undervoltage_latch = uv17_q;
  // cells 1 to 16 keep their flags elsewhere and clear on this pulse
  assign uv_clear_pulse = clr_q;
  // stays on while the field holds the code; writing any other value stops it
  assign fuse_drive = fuse_drive_q;
endmodule
`default_nettype wire

//--- verification/cfb_master.sv
/* serial master model: 24-bit mode 0 frames, msb first.
   assumes it drives pins on mclk falling edges. */
`timescale 1ns/1ps
`default_nettype none
module cfb_master (
  // clock
  input wire logic mclk,
  // serial pins
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  // read result, one-cycle strobe
  output logic rd_done,
  output logic [15:0] rd_word
);
  initial begin
    {sclk, mosi, rd_done} = 3'h0;
    rd_word = 16'h0000;
    cs_n = 1'b1;
  end
  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [15:0] d);
    logic [23:0] f;
    f = {wr, a, d};
    @(negedge mclk) cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = f[i];
      sclk = 1'b0;
      repeat (2) @(negedge mclk);
      // miso has settled since the previous fall
      rd_word = {rd_word[14:0], miso};
      sclk = 1'b1;
      repeat (2) @(negedge mclk);
    end
    sclk = 1'b0;
    cs_n = 1'b1;
    // released line must not keep its last bit
    mosi = ~mosi;
    rd_done = !wr;
    @(negedge mclk) rd_done = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

//--- verification/cfb_regs_sva.sv
/* port assertions for the register slice.
   assumes one clock, mclk, and synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module cfb_regs_sva #(
  parameter int CELLS = 17
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic miso_oe_n,
  input wire logic cell17_uv_detect,
  input wire logic cell17_undervoltage_latch,
  input wire logic uv_clear_pulse,
  input wire logic fuse_drive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> !cell17_undervoltage_latch && !fuse_drive && !uv_clear_pulse)
    else $error("outputs not cleared by reset");
  a_detect_sets: assert property (
    cell17_uv_detect |=> cell17_undervoltage_latch)
    else $error("detect did not set flag");
  a_rise_needs_det: assert property (
    $rose(cell17_undervoltage_latch) |-> $past(cell17_uv_detect))
    else $error("flag rose without detect");
  a_fall_with_clear: assert property (
    $fell(cell17_undervoltage_latch) && !$past(rst) |-> uv_clear_pulse)
    else $error("flag fell without clear");
  a_clear_one_cycle: assert property (
    uv_clear_pulse |=> !uv_clear_pulse)
    else $error("clear pulse too long");
  a_clear_after_frame: assert property (
    uv_clear_pulse |-> cs_n && $past(cs_n))
    else $error("clear inside a frame");
  a_fuse_after_frame: assert property (
    $changed(fuse_drive) |-> cs_n && $past(cs_n))
    else $error("fuse moved inside a frame");
  a_oe_tracks_cs: assert property (miso_oe_n == $past(cs_n))
    else $error("miso enable wrong");
  c_flag: cover property ($rose(cell17_undervoltage_latch));
  c_clear: cover property (uv_clear_pulse);
  c_fuse: cover property ($rose(fuse_drive));
endmodule
bind cfb_regs cfb_regs_sva #(.CELLS(CELLS)) i_cfb_regs_sva (.mclk, .rst,
  .cs_n, .miso_oe_n, .cell17_uv_detect, .cell17_undervoltage_latch,
  .uv_clear_pulse, .fuse_drive);
`default_nettype wire

//--- verification/test_cfb_regs.sv
/* self-checking bench for the register slice.
   assumes cfb_master drives the serial pins on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module test_cfb_regs;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe_n, rd_done;
  logic cell17_uv_detect = 1'b0;
  logic [cfb_pkg::CELLS-1:0] cell_balance_on = 17'h00000;
  logic cell17_undervoltage_latch, uv_clear_pulse, fuse_drive;
  logic [15:0] rd_word;
  logic [15:0] exp_q[$];
  logic [31:0] r;
  logic [6:0] ofs [2] = '{cfb_pkg::UV_FLAGS_LOW_OFS,
                          cfb_pkg::UV_FLAGS_HIGH_OFS};
  int err_count = 0;
  int comparisons = 0;
  int clears = 0;
  int seed = 25094;
  always #5 mclk = ~mclk;
  cfb_regs #(.CELLS(17)) i_cfb_regs (.mclk, .rst, .sclk, .cs_n, .mosi,
    .miso, .miso_oe_n, .cell17_uv_detect, .cell_balance_on,
    .cell17_undervoltage_latch, .uv_clear_pulse, .fuse_drive);
  cfb_master i_cfb_master (.mclk, .miso, .sclk, .cs_n, .mosi, .rd_done,
    .rd_word);
  task automatic check(input logic [15:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_cfb_master.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_cfb_master.xfer(1'b1, a, d);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rd_done === 1'b1)
      check(rd_word, exp_q.pop_front(), "read word");
    if (uv_clear_pulse === 1'b1)
      clears++;
  end
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    rd(cfb_pkg::UV_FLAGS_HIGH_OFS, 16'h0000);
    rd(cfb_pkg::FUSE_TRIGGER_OFS, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      cell_balance_on = r[16:0];
      // refused write must not disturb the live status
      wr(cfb_pkg::BAL_STATE_LOW_OFS, ~r[15:0]);
      rd(cfb_pkg::BAL_STATE_LOW_OFS, r[15:0]);
      rd(cfb_pkg::BAL_STATE_HIGH_OFS, {15'h0000, r[16]});
    end
    foreach (ofs[k]) begin
      @(negedge mclk) cell17_uv_detect = 1'b1;
      @(negedge mclk) cell17_uv_detect = 1'b0;
      repeat (20) @(negedge mclk);
      check({15'h0000, cell17_undervoltage_latch}, 16'h0001, "flag");
      rd(cfb_pkg::UV_FLAGS_HIGH_OFS, 16'h0001);
      wr(ofs[k], cfb_pkg::CLEAR_VALUE);
      check({15'h0000, cell17_undervoltage_latch}, 16'h0000, "flag");
      check(16'(clears), 16'(k + 1), "clear pulses");
    end
    r = $random(seed);
    wr(cfb_pkg::FUSE_TRIGGER_OFS, {r[7:0], cfb_pkg::FUSE_CODE});
    check({15'h0000, fuse_drive}, 16'h0001, "fuse");
    rd(cfb_pkg::FUSE_TRIGGER_OFS, {8'h00, cfb_pkg::FUSE_CODE});
    wr(7'h60, 16'h0000);
    check({15'h0000, fuse_drive}, 16'h0001, "fuse");
    wr(cfb_pkg::FUSE_TRIGGER_OFS, 16'h00fa);
    check({15'h0000, fuse_drive}, 16'h0000, "fuse");
    rd(cfb_pkg::FUSE_TRIGGER_OFS, 16'h00fa);
    repeat (5) @(negedge mclk);
    check(16'(exp_q.size()), 16'h0000, "reads pending");
    report_and_stop();
  end
  // about 23 frames of 100 cycles each, with wide margin
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
